// ==== core/lpst_params.svh ====
`ifndef LPST_PARAMS_SVH
`define LPST_PARAMS_SVH

// Register byte offsets.
`define LPST_OFS_DATA 8'h00
`define LPST_OFS_CTRL 8'h04
`define LPST_OFS_STATION_ADDRESS 8'h08
`define LPST_OFS_SMASK 8'h0c
`define LPST_OFS_FLAG 8'h10
`define LPST_OFS_FCLR 8'h14
`define LPST_OFS_BAUD 8'h18

// Control register field positions.
`define LPST_CTRL_EN 16
`define LPST_CTRL_PRSC 13
`define LPST_CTRL_SEL 11
`define LPST_CTRL_LP 10
`define LPST_CTRL_DBL 9
`define LPST_CTRL_FEEN 8
`define LPST_CTRL_MODE 6
`define LPST_CTRL_MNE 5
`define LPST_CTRL_REN 4
`define LPST_CTRL_TB9 3
`define LPST_CTRL_RB9 2
`define LPST_CTRL_TIEN 1
`define LPST_CTRL_RIEN 0

// Flag and clear register bit positions.
`define LPST_FLAG_FE 2
`define LPST_FLAG_TI 1
`define LPST_FLAG_RI 0

// Baud control register field positions.
`define LPST_BAUD_SELF 16

// Reset values.
`define LPST_CTRL_RST 32'h0000e000

// Timing counts in clock cycles or source events.
`define LPST_M0_DIV 12
`define LPST_M0_HALF (`LPST_M0_DIV / 2)
`define LPST_OVS 4
`define LPST_M2_SAMP 20'h00010
`define LPST_TMR_SAMP 20'h00008

`endif

// ==== core/lpst_pkg.sv ====
package lpst_pkg;

    // Register bus request from the master.
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } lpst_bus_s;

    typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} lpst_tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} lpst_rx_e;

    // Settings that steer the baud generator.
    typedef struct packed {
        logic en;
        logic lp;
        logic [2:0] prsc;
        logic [1:0] sel;
        logic dbl;
        logic [1:0] mode;
        logic self_brg;
        logic [15:0] brg;
    } lpst_baud_cfg_s;

    // Baud generator state.
    typedef struct packed {
        logic ext_q;
        logic int_q;
        logic tmr_q;
        logic [6:0] pre_cnt;
        logic [19:0] div_cnt;
        logic [2:0] m0_cnt;
        logic samp_tick;
        logic half_tick;
    } lpst_baud_s;

    // Transceiver core state.
    typedef struct packed {
        lpst_baud_cfg_s cfg;
        logic feen;
        logic mne;
        logic ren;
        logic tb9;
        logic rb9;
        logic tien;
        logic rien;
        logic [7:0] station_address;
        logic [7:0] smask;
        logic [7:0] rx_buf;
        logic ri;
        logic ti;
        logic fe;
        logic [31:0] rdata;
        logic irq;
        lpst_tx_e tx_st;
        logic [9:0] tx_sh;
        logic [3:0] tx_bits;
        logic [1:0] tx_sub;
        logic txd;
        logic rxd_out;
        logic rxd_oe;
        logic m0_rx;
        lpst_rx_e rx_st;
        logic [8:0] rx_sh;
        logic [3:0] rx_bits;
        logic [1:0] rx_sub;
    } lpst_core_s;

endpackage

// ==== core/lpst_baud.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "lpst_params.svh"

module lpst_baud (
    input wire logic clk,
    input wire logic reset,
    input wire lpst_pkg::lpst_baud_cfg_s cfg,
    input wire logic ext_osc,
    input wire logic int_osc,
    input wire logic tmr_toggle,
    output logic samp_tick,
    output logic half_tick
);
    import lpst_pkg::*;

    lpst_baud_s s_reg;
    lpst_baud_s s_next;

    ////////////////////////////////////////////////////////////////////////////
    // Source events per oversample tick for the chosen baud source.
    function automatic logic [19:0] samp_div(input lpst_baud_cfg_s c);
        logic [19:0] d;
        d = 20'h00001;
        if (c.lp) begin
            d = 20'h00001;
        end else if (c.mode == 2'b10) begin
            d = `LPST_M2_SAMP >> c.dbl;
        end else if (c.self_brg) begin
            d = (({4'h0, c.brg} << 3) + 20'h00008) >> c.dbl;
        end else begin
            d = `LPST_TMR_SAMP >> c.dbl;
        end
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Builds the kernel enable, the prescaler and the two tick outputs.
    always_comb begin
        logic k_en;
        logic evt;
        k_en = 1'b0;
        evt = 1'b0;
        s_next = s_reg;
        s_next.samp_tick = 1'b0;
        s_next.half_tick = 1'b0;
        s_next.ext_q = ext_osc;
        s_next.int_q = int_osc;
        s_next.tmr_q = tmr_toggle;
        case (cfg.sel)
            2'b01: k_en = ext_osc & ~s_reg.ext_q;
            2'b10: k_en = int_osc & ~s_reg.int_q;
            default: k_en = 1'b1;
        endcase
        if (!cfg.en) begin
            s_next.pre_cnt = 7'h00;
            s_next.div_cnt = 20'h00000;
            s_next.m0_cnt = 3'h0;
        end else begin
            if (s_reg.m0_cnt == 3'(`LPST_M0_HALF - 1)) begin
                s_next.m0_cnt = 3'h0;
                s_next.half_tick = 1'b1;
            end else begin
                s_next.m0_cnt = s_reg.m0_cnt + 3'h1;
            end
            if (cfg.lp) begin
                if (k_en) begin
                    if (s_reg.pre_cnt == 7'((8'h01 << cfg.prsc) - 8'h01)) begin
                        s_next.pre_cnt = 7'h00;
                        evt = 1'b1;
                    end else begin
                        s_next.pre_cnt = s_reg.pre_cnt + 7'h01;
                    end
                end
            end else if (cfg.mode == 2'b10) begin
                evt = 1'b1;
            end else if (cfg.self_brg) begin
                evt = k_en;
            end else begin
                evt = tmr_toggle ^ s_reg.tmr_q;
            end
            if (evt) begin
                if (s_reg.div_cnt >= samp_div(cfg) - 20'h00001) begin
                    s_next.div_cnt = 20'h00000;
                    s_next.samp_tick = 1'b1;
                end else begin
                    s_next.div_cnt = s_reg.div_cnt + 20'h00001;
                end
            end
        end
    end

    // Registers the generator state.
    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign samp_tick = s_reg.samp_tick;
    assign half_tick = s_reg.half_tick;

endmodule

`default_nettype wire

// ==== core/lpst_top.sv ====
// Functional notes
// - Config on bus clock, serial on kernel; here serial also runs on bus clock, kernel source as enable.
// - Keeps running; disable stops baud generation.
// - Kernel clock from bus, external, internal.
// - Low-power option prescales kernel clock by powers.
// - Timer baud uses toggle output edges.
// - Low-power option allows only modes 1, 3.
// - Mode 0: master, clock out, bidirectional data.
// - Mode 0 at bus clock over twelve.
// - Mode 0 send: data write, LSB first.
// - Mode 0 receive after enable and RI clear.
// - Mode 1: start, eight data, stop.
// - Mode 1 baud from generator or timer.
// - Async send starts on write, any enable.
// - Async receive fills data port per frame.
// - Modes 2, 3 add a ninth bit.
// - Mode 2 baud fixed from bus clock.
// - Mode 3 is mode 2 with programmable baud.
// - Sticky frame error on bad stop bit.
// - Multi-node drops data and unmatched frames.
// - Match given and broadcast masked addresses.
// - Mode 2 rate: bus times doubler over 64.
`timescale 1ns/100ps
`default_nettype none
`include "lpst_params.svh"

module lpst_top (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire lpst_pkg::lpst_bus_s BUS_REQ,
    output logic [31:0] RDATA,
    output logic TXD_OUT,
    input wire logic RXD_IN,
    output logic RXD_OUT,
    output logic RXD_OE,
    input wire logic EXT_SLOW_OSC,
    input wire logic INT_SLOW_OSC,
    input wire logic TIMER_TOGGLE,
    output logic IRQ
);
    import lpst_pkg::*;

    lpst_core_s s_reg;
    lpst_core_s s_next;
    logic samp_tick;
    logic half_tick;

    ////////////////////////////////////////////////////////////////////////////
    // True when the address hits the given or the broadcast address.
    function automatic logic addr_match(input logic [7:0] a, input logic [7:0] sa,
                                        input logic [7:0] sm);
        logic [7:0] bcast;
        bcast = sa | sm;
        return (((a ^ sa) & sm) == 8'h00) || (((a ^ bcast) & sm) == 8'h00);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Serial timing runs as enables; the selected kernel source paces only the low-power and self-generator baud.
    lpst_baud u_baud (
        .clk(SYS_CLK),
        .reset(RESET),
        .cfg(s_reg.cfg),
        .ext_osc(EXT_SLOW_OSC),
        .int_osc(INT_SLOW_OSC),
        .tmr_toggle(TIMER_TOGGLE),
        .samp_tick(samp_tick),
        .half_tick(half_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register access, transmitter, receiver and request logic.
    always_comb begin
        logic wr_hit;
        logic mode_ok;
        logic [3:0] nb;
        logic [7:0] rx_data;
        logic rx_ninth;
        logic [9:0] m0_sh;
        wr_hit = 1'b0;
        mode_ok = 1'b0;
        nb = 4'h9;
        rx_data = 8'h00;
        rx_ninth = 1'b0;
        m0_sh = 10'h000;
        s_next = s_reg;
        s_next.rdata = 32'h00000000;

        // Software writes land first so that hardware events win the cycle.
        if (BUS_REQ.wr) begin
            case (BUS_REQ.addr)
                `LPST_OFS_CTRL: begin
                    s_next.cfg.en = BUS_REQ.wdata[`LPST_CTRL_EN];
                    s_next.cfg.prsc = BUS_REQ.wdata[`LPST_CTRL_PRSC +: 3];
                    s_next.cfg.sel = BUS_REQ.wdata[`LPST_CTRL_SEL +: 2];
                    s_next.cfg.lp = BUS_REQ.wdata[`LPST_CTRL_LP];
                    s_next.cfg.dbl = BUS_REQ.wdata[`LPST_CTRL_DBL];
                    s_next.feen = BUS_REQ.wdata[`LPST_CTRL_FEEN];
                    s_next.cfg.mode = BUS_REQ.wdata[`LPST_CTRL_MODE +: 2];
                    s_next.mne = BUS_REQ.wdata[`LPST_CTRL_MNE];
                    s_next.ren = BUS_REQ.wdata[`LPST_CTRL_REN];
                    s_next.tb9 = BUS_REQ.wdata[`LPST_CTRL_TB9];
                    s_next.rb9 = BUS_REQ.wdata[`LPST_CTRL_RB9];
                    s_next.tien = BUS_REQ.wdata[`LPST_CTRL_TIEN];
                    s_next.rien = BUS_REQ.wdata[`LPST_CTRL_RIEN];
                end
                `LPST_OFS_STATION_ADDRESS: s_next.station_address = BUS_REQ.wdata[7:0];
                `LPST_OFS_SMASK: s_next.smask = BUS_REQ.wdata[7:0];
                `LPST_OFS_FCLR: begin
                    if (BUS_REQ.wdata[`LPST_FLAG_FE]) begin
                        s_next.fe = 1'b0;
                    end
                    if (BUS_REQ.wdata[`LPST_FLAG_TI]) begin
                        s_next.ti = 1'b0;
                    end
                    if (BUS_REQ.wdata[`LPST_FLAG_RI]) begin
                        s_next.ri = 1'b0;
                    end
                end
                `LPST_OFS_BAUD: begin
                    s_next.cfg.self_brg = BUS_REQ.wdata[`LPST_BAUD_SELF];
                    s_next.cfg.brg = BUS_REQ.wdata[15:0];
                end
                `LPST_OFS_DATA: wr_hit = 1'b1;
                default: wr_hit = 1'b0;
            endcase
        end

        // Read data appears in the cycle after the strobe only.
        if (BUS_REQ.rd) begin
            case (BUS_REQ.addr)
                `LPST_OFS_DATA: s_next.rdata = {24'h000000, s_reg.rx_buf};
                `LPST_OFS_CTRL: s_next.rdata = {15'h0000, s_reg.cfg.en,
                    s_reg.cfg.prsc, s_reg.cfg.sel, s_reg.cfg.lp, s_reg.cfg.dbl,
                    s_reg.feen, s_reg.cfg.mode, s_reg.mne, s_reg.ren, s_reg.tb9,
                    s_reg.rb9, s_reg.tien, s_reg.rien};
                `LPST_OFS_STATION_ADDRESS: s_next.rdata = {24'h000000, s_reg.station_address};
                `LPST_OFS_SMASK: s_next.rdata = {24'h000000, s_reg.smask};
                `LPST_OFS_FLAG: s_next.rdata = {29'h00000000, s_reg.fe, s_reg.ti,
                    s_reg.ri};
                `LPST_OFS_BAUD: s_next.rdata = {15'h0000, s_reg.cfg.self_brg,
                    s_reg.cfg.brg};
                default: s_next.rdata = 32'h00000000;
            endcase
        end

        // Modes 0 and 2 are shut out under the low-power option.
        mode_ok = s_reg.cfg.en && !(s_reg.cfg.lp && !s_reg.cfg.mode[0]);
        nb = s_reg.cfg.mode[1] ? 4'ha : 4'h9;

        // Transmitter, also the mode 0 shift engine in both directions.
        case (s_reg.tx_st)
            TX_IDLE: begin
                s_next.txd = 1'b1;
                if (mode_ok && s_reg.cfg.mode != 2'b00 && wr_hit) begin
                    s_next.tx_st = TX_ASYNC;
                    s_next.tx_sh = {1'b1, s_reg.tb9 | ~s_reg.cfg.mode[1],
                                    BUS_REQ.wdata[7:0]};
                    s_next.tx_bits = 4'h0;
                    s_next.tx_sub = 2'h0;
                    s_next.txd = 1'b0;
                end else if (mode_ok && s_reg.cfg.mode == 2'b00
                             && ((wr_hit && !s_reg.ren)
                             || (s_reg.ren && !s_reg.ri))) begin
                    s_next.tx_st = TX_SYNC;
                    s_next.m0_rx = s_reg.ren;
                    s_next.tx_sh = {2'b00, s_reg.ren ? 8'h00 : BUS_REQ.wdata[7:0]};
                    s_next.rxd_out = s_reg.ren ? 1'b0 : BUS_REQ.wdata[0];
                    s_next.rxd_oe = ~s_reg.ren;
                    s_next.tx_bits = 4'h0;
                    s_next.tx_sub = 2'h0;
                end
            end
            TX_ASYNC: begin
                if (samp_tick) begin
                    if (s_reg.tx_sub == 2'(`LPST_OVS - 1)) begin
                        s_next.tx_sub = 2'h0;
                        if (s_reg.tx_bits == nb) begin
                            s_next.tx_st = TX_IDLE;
                            s_next.ti = 1'b1;
                        end else begin
                            s_next.txd = s_reg.tx_sh[0];
                            s_next.tx_sh = {1'b1, s_reg.tx_sh[9:1]};
                            s_next.tx_bits = s_reg.tx_bits + 4'h1;
                        end
                    end else begin
                        s_next.tx_sub = s_reg.tx_sub + 2'h1;
                    end
                end
            end
            TX_SYNC: begin
                if (half_tick) begin
                    if (s_reg.tx_sub[0] == 1'b0) begin
                        s_next.txd = 1'b0;
                        s_next.tx_sub = 2'h1;
                    end else begin
                        // Data is sampled as the shift clock rises.
                        s_next.txd = 1'b1;
                        s_next.tx_sub = 2'h0;
                        m0_sh = {2'b00, RXD_IN, s_reg.tx_sh[7:1]};
                        s_next.tx_sh = m0_sh;
                        s_next.rxd_out = m0_sh[0];
                        s_next.tx_bits = s_reg.tx_bits + 4'h1;
                        if (s_reg.tx_bits == 4'h7) begin
                            s_next.tx_st = TX_IDLE;
                            s_next.rxd_oe = 1'b0;
                            if (s_reg.m0_rx) begin
                                s_next.rx_buf = m0_sh[7:0];
                                s_next.ri = 1'b1;
                            end else begin
                                s_next.ti = 1'b1;
                            end
                        end
                    end
                end
            end
            default: s_next.tx_st = TX_IDLE;
        endcase

        // Asynchronous receiver, sampling each bit at its middle tick.
        rx_data = s_reg.cfg.mode[1] ? s_reg.rx_sh[7:0] : s_reg.rx_sh[8:1];
        rx_ninth = s_reg.cfg.mode[1] ? s_reg.rx_sh[8] : RXD_IN;
        if (!(mode_ok && s_reg.ren && s_reg.cfg.mode != 2'b00)) begin
            s_next.rx_st = RX_IDLE;
        end else if (samp_tick) begin
            case (s_reg.rx_st)
                RX_IDLE: begin
                    if (!RXD_IN) begin
                        s_next.rx_st = RX_START;
                        s_next.rx_sub = 2'h0;
                    end
                end
                RX_START: begin
                    if (s_reg.rx_sub == 2'h1) begin
                        s_next.rx_st = RXD_IN ? RX_IDLE : RX_BITS;
                        s_next.rx_sub = 2'h0;
                        s_next.rx_bits = 4'h0;
                    end else begin
                        s_next.rx_sub = s_reg.rx_sub + 2'h1;
                    end
                end
                RX_BITS: begin
                    if (s_reg.rx_sub == 2'(`LPST_OVS - 1)) begin
                        s_next.rx_sub = 2'h0;
                        if (s_reg.rx_bits == nb - 4'h1) begin
                            s_next.rx_st = RX_IDLE;
                            if (!RXD_IN) begin
                                s_next.fe = 1'b1;
                            end
                            if (!s_reg.ri && (!s_reg.mne
                                || (rx_ninth && RXD_IN
                                && addr_match(rx_data, s_reg.station_address,
                                              s_reg.smask)))) begin
                                s_next.rx_buf = rx_data;
                                s_next.rb9 = rx_ninth;
                                s_next.ri = 1'b1;
                            end
                        end else begin
                            s_next.rx_sh = {RXD_IN, s_reg.rx_sh[8:1]};
                            s_next.rx_bits = s_reg.rx_bits + 4'h1;
                        end
                    end else begin
                        s_next.rx_sub = s_reg.rx_sub + 2'h1;
                    end
                end
                default: s_next.rx_st = RX_IDLE;
            endcase
        end

        // The request follows the flags after this cycle's sets and clears.
        s_next.irq = (s_next.ri & s_reg.rien) | (s_next.ti & s_reg.tien)
                   | (s_next.fe & s_reg.feen);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and serial state share one register set on the clock.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            s_reg <= '0;
            s_reg.cfg.prsc <= 3'(`LPST_CTRL_RST >> `LPST_CTRL_PRSC);
            s_reg.txd <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs come straight from the state register.
    assign RDATA = s_reg.rdata;
    assign TXD_OUT = s_reg.txd;
    assign RXD_OUT = s_reg.rxd_out;
    assign RXD_OE = s_reg.rxd_oe;
    assign IRQ = s_reg.irq;

endmodule

`default_nettype wire

// ==== verif/lpst_top_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////
// Port-level checks on the transceiver top.
module lpst_chk (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire lpst_pkg::lpst_bus_s BUS_REQ,
    input wire logic [31:0] RDATA,
    input wire logic TXD_OUT,
    input wire logic RXD_OUT,
    input wire logic RXD_OE,
    input wire logic IRQ
);
    import lpst_pkg::*;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    // Outputs leave reset quiet, with the serial line idling high.
    a_reset_idle: assert property (
        $fell(RESET) |-> TXD_OUT && !RXD_OE && !IRQ && RDATA == 32'h0)
        else $error("outputs not idle after reset");
    // Read data shows only in the cycle after a read strobe.
    a_read_idle: assert property (
        !BUS_REQ.rd |=> RDATA == 32'h0) else $error("read data outside read cycle");
    // Byte-wide registers and the unused hole read zero above their fields.
    a_byte_regs: assert property (
        BUS_REQ.rd && BUS_REQ.addr inside {8'h00, 8'h08, 8'h0c, 8'h1c}
        |=> RDATA[31:8] == 24'h0) else $error("byte register wider than a byte");
    // Only the three flags show in the flag register.
    a_flag_width: assert property (
        BUS_REQ.rd && BUS_REQ.addr == 8'h10 |=> RDATA[31:3] == 29'h0)
        else $error("flag register reserved bits set");
    // Control reads nothing above the enable bit.
    a_ctrl_width: assert property (
        BUS_REQ.rd && BUS_REQ.addr == 8'h04 |=> RDATA[31:17] == 15'h0)
        else $error("control reserved bits set");
    // Turning every interrupt enable off drops the request.
    a_irq_masked: assert property (
        BUS_REQ.wr && BUS_REQ.addr == 8'h04 && BUS_REQ.wdata[8] == 1'b0
        && BUS_REQ.wdata[1:0] == 2'b00 |-> ##3 !IRQ) else $error("request while masked");
    // Each low half of the shift clock lasts six bus cycles.
    a_shift_low: assert property (
        $fell(TXD_OUT) && RXD_OE |-> (!TXD_OUT) [*6] ##1 TXD_OUT)
        else $error("shift clock low phase wrong");
    // Shift data changes only as the shift clock rises.
    a_shift_data: assert property (
        RXD_OE && $past(RXD_OE) && !$rose(TXD_OUT) |-> $stable(RXD_OUT))
        else $error("shift data moved off the clock");
    // The data pin is still driven 80 cycles after an eight-bit shift starts.
    a_shift_frame: assert property (
        $rose(RXD_OE) |-> ##80 RXD_OE) else $error("shift frame too short");
endmodule

bind lpst_top lpst_chk chk_u (
    .SYS_CLK(SYS_CLK),
    .RESET(RESET),
    .BUS_REQ(BUS_REQ),
    .RDATA(RDATA),
    .TXD_OUT(TXD_OUT),
    .RXD_OUT(RXD_OUT),
    .RXD_OE(RXD_OE),
    .IRQ(IRQ)
);
`default_nettype wire

// ==== verif/lpst_node.sv ====
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////
// Remote serial node; its line idles high like a pulled-up wire.
module lpst_node (
    input wire logic clk,
    input wire logic txd,
    input wire logic pin,
    output logic line
);
    initial line = 1'b1;

    // Sends nb levels, start bit first, each held bc cycles.
    task automatic send(input int nb, input int bc, input logic [10:0] b);
        @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            line <= b[i];
            repeat (bc) @(posedge clk);
        end
        line <= 1'b1;
    endtask

    // Samples nb levels of a frame mid-bit, start bit first.
    task automatic get(input int nb, input int bc, output logic [10:0] d);
        d = '0;
        @(negedge txd);
        repeat (bc / 2) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            d[i] = txd;
            repeat (bc) @(posedge clk);
        end
    endtask

    // Shift slave: offers din and captures the pin on each falling clock.
    task automatic m0(input logic [7:0] din, output logic [7:0] dout);
        for (int i = 0; i < 8; i++) begin
            @(negedge txd);
            line <= din[i];
            dout[i] = pin;
        end
        repeat (6) @(posedge clk);
        line <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== verif/lpst_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////
module lpst_top_tb;
    import lpst_pkg::*;
    localparam logic [31:0] c_en = 32'h10000, c_m1 = 32'h40, c_m2 = 32'h80, c_m3 = 32'hc0;
    localparam logic [31:0] c_ren = 32'h10, c_mne = 32'h20, c_tb9 = 32'h8;
    localparam logic [31:0] c_dbl = 32'h200, c_lp = 32'h400, c_ie = 32'h103;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ext = 1'b0;
    logic slow = 1'b0;
    logic tmr = 1'b0;
    lpst_bus_s req = '0;
    logic [31:0] rdata;
    logic txd, rxo, oe, irq, line, pin;
    logic [7:0] g8;
    logic [8:0] fr [4] = '{9'h069, 9'h112, 9'h16d, 9'h1ff};
    int fail_count = 0;
    int n_checks = 0;

    logic [3:0] cyc = 4'h0;

    // Bus clock; the three slow sources step on its rising edge.
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 4'h1;
        ext <= cyc[2];
        slow <= cyc[3];
        tmr <= cyc[1];
    end
    // The shared data pin follows whoever drives it.
    assign pin = (oe === 1'b1) ? rxo : line;

    lpst_top dut_u (.SYS_CLK(clk), .RESET(rst), .BUS_REQ(req), .RDATA(rdata),
        .TXD_OUT(txd), .RXD_IN(pin), .RXD_OUT(rxo), .RXD_OE(oe),
        .EXT_SLOW_OSC(ext), .INT_SLOW_OSC(slow), .TIMER_TOGGLE(tmr), .IRQ(irq));
    lpst_node node_u (.clk(clk), .txd(txd), .pin(pin), .line(line));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    // Reads a register and compares the word seen in the following cycle.
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 chk(rdata, e);
    endtask

    // Sends one frame, with a second data write while busy that must be dropped.
    task automatic txf(input logic [31:0] c, input int nb, input int bc, input logic [10:0] e);
        logic [10:0] g;
        wr(8'h04, c);
        fork
            node_u.get(nb, bc, g);
            begin
                wr(8'h00, {24'h0, e[8:1]});
                wr(8'h00, {24'h0, ~e[8:1]});
            end
        join
        chk({21'h0, g}, {21'h0, e});
        rchk(8'h10, 32'h2);
        chk({31'h0, irq}, {31'h0, c[1]});
        wr(8'h14, 32'h7);
    endtask

    // A data write under this setting must leave both pins idle.
    task automatic quiet(input logic [31:0] c);
        int n = 0;
        wr(8'h04, c);
        wr(8'h00, 32'h81);
        repeat (100) begin
            @(posedge clk);
            n += int'(txd !== 1'b1 || oe !== 1'b0);
        end
        chk(32'(n), 32'h0);
    endtask

    task automatic rxf(input logic [10:0] b);
        node_u.send(11, 32, b);
        repeat (32) @(posedge clk);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence: registers, every baud source, receive, address filter, shift mode.
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rchk(8'h04, 32'h0000e000);
        rchk(8'h10, 32'h0);
        rchk(8'h1c, 32'h0);
        wr(8'h08, 32'h69);
        rchk(8'h08, 32'h69);
        txf(c_en | c_m2 | c_tb9 | c_ie, 11, 64, {2'b11, 8'ha5, 1'b0});
        txf(c_en | c_m2 | c_dbl, 11, 32, {2'b10, 8'h5a, 1'b0});
        wr(8'h18, 32'h10001);
        txf(c_en | c_m1, 10, 64, {2'b01, 8'h3c, 1'b0});
        wr(8'h18, 32'h0);
        txf(c_en | c_m3 | c_tb9, 11, 64, {2'b11, 8'h96, 1'b0});
        txf(c_en | c_lp | c_m3 | 32'h800, 11, 32, {2'b10, 8'h0f, 1'b0});
        txf(c_en | c_lp | c_m1 | 32'h3000, 10, 128, {2'b01, 8'hf0, 1'b0});
        txf(c_en | c_lp | c_m3 | 32'h4000, 11, 16, {2'b10, 8'h33, 1'b0});
        quiet(c_en | c_lp);
        quiet(c_en | c_lp | c_m2);
        quiet(c_m1);
        wr(8'h04, c_en | c_m2 | c_dbl | c_ren | c_ie);
        rxf({2'b10, 8'hc3, 1'b0});
        rchk(8'h00, 32'hc3);
        rchk(8'h10, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rxf({2'b11, 8'h99, 1'b0});
        rchk(8'h00, 32'hc3);
        wr(8'h14, 32'h1);
        rxf({2'b00, 8'h55, 1'b0});
        repeat (400) @(posedge clk);
        rchk(8'h10, 32'h5);
        wr(8'h14, 32'h1);
        rxf({2'b10, 8'h66, 1'b0});
        rchk(8'h10, 32'h5);
        rchk(8'h00, 32'h66);
        wr(8'h0c, 32'hfb);
        wr(8'h04, c_en | c_m2 | c_dbl | c_ren | c_mne);
        wr(8'h14, 32'h7);
        foreach (fr[i]) begin
            rxf({1'b1, fr[i], 1'b0});
            rchk(8'h10, {31'h0, i > 1});
            wr(8'h14, 32'h7);
        end
        wr(8'h04, c_en | c_ie);
        fork
            node_u.m0(8'h00, g8);
            wr(8'h00, 32'hb4);
        join
        chk({24'h0, g8}, 32'hb4);
        repeat (12) @(posedge clk);
        rchk(8'h10, 32'h2);
        wr(8'h14, 32'h7);
        fork
            node_u.m0(8'h4b, g8);
            wr(8'h04, c_en | c_ren);
        join
        repeat (12) @(posedge clk);
        rchk(8'h00, 32'h4b);
        wr(8'h04, 32'h0);
        final_report();
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        #2000000;
        fail_count++;
        final_report();
    end
endmodule
`default_nettype wire
